// file: rtl/cbu_branch.sv
/*
 * Conditional relative branch unit: tests one flag or a signed flag
 * combination and, when the test holds, loads pc + offset + 1.
 * Assumes decode holds a request until ready_o, the program counter
 * is stable while a request is offered, and flag writes of the
 * previous instruction arrive on the same clock as flag_wr_i.
 */
// How it works
// - Positive branch taken only while the negative flag is clear.
// - Signed greater-or-equal taken when negative xor overflow is 0.
// - Signed less-than taken when negative xor overflow is 1.
// - Half-carry-set branch taken only while the half carry is 1.
// - Half-carry-clear branch taken only while the half carry is 0.
// - Transfer-bit-set branch taken only when the transfer bit is 1.
// - Transfer-bit-clear branch taken only when the transfer bit is 0.
// - Overflow-set branch taken only when the overflow flag is 1.
// - A taken branch loads the counter with pc plus offset plus one.
// - No flag is written; one cycle falling through, two when taken.
`timescale 1ns/1ps
module cbu_branch (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_valid_i,
    input wire cbu_pkg::cbu_req_t req_i,
    input wire logic [cbu_pkg::CBU_PC_W-1:0] pc_i,
    input wire cbu_pkg::cbu_flags_t flags_i,
    input wire logic flag_wr_i,
    input wire cbu_pkg::cbu_flags_t flag_wdata_i,
    output logic ready_o,
    output logic pc_load_o,
    output logic [cbu_pkg::CBU_PC_W-1:0] pc_target_o,
    output logic done_o,
    output logic taken_o,
    output logic flag_wr_o
);
    import cbu_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    cbu_state_t state;
    cbu_state_t next_state;
    cbu_flags_t cur_flags;
    logic cond;
    logic accept;
    logic [CBU_PC_W-1:0] ext_ofs;
    logic [CBU_PC_W-1:0] next_target;

    // ************************************************************
    // Flag view and condition test
    // ************************************************************

    // Forward a flag write of the same cycle; the register file only
    // shows it one edge later, too late for a back-to-back branch.
    // Only the write of the instruction just before is forwarded; an
    // older write must already stand in flags_i.
    assign cur_flags = flag_wr_i ? flag_wdata_i : flags_i;

    // One test per selector; every code is legal, so no default
    always_comb begin
        cond = 1'b0;
        unique case (req_i.op)
            CBU_BR_POSITIVE: cond = ~cur_flags.neg;
            CBU_BR_SGE: cond = ~(cur_flags.neg ^ cur_flags.ovf);
            CBU_BR_SLT: cond = cur_flags.neg ^ cur_flags.ovf;
            CBU_BR_HC_SET: cond = cur_flags.half;
            CBU_BR_HC_CLR: cond = ~cur_flags.half;
            CBU_BR_TB_SET: cond = cur_flags.xfer;
            CBU_BR_TB_CLR: cond = ~cur_flags.xfer;
            CBU_BR_OV_SET: cond = cur_flags.ovf;
        endcase
    end

    // ************************************************************
    // Target arithmetic
    // ************************************************************

    // Offset counts words in two's complement
    assign ext_ofs = {{CBU_EXT_W{req_i.offset[CBU_OFS_W-1]}},
                      req_i.offset};
    // Wraps modulo the counter width, as the program space does
    assign next_target = pc_i + ext_ofs + CBU_PC_ONE;

    // ************************************************************
    // Sequencer
    // ************************************************************

    // Cycle walk of one branch, counted from the accepting edge:
    //   falling through - done_o is high for the next cycle, and a new
    //   request may be accepted at the very next edge;
    //   taken - pc_load_o and the target stand for the next cycle,
    //   ready_o is low for that cycle only, and done_o follows one
    //   cycle later together with ready_o.
    // Decode has no error path: a refused request just waits, so the
    // cost of a taken branch is one stalled decode cycle.

    // Requests are refused during the second cycle of a taken branch
    assign ready_o = (state == CBU_ST_IDLE);
    assign accept = req_valid_i & ready_o;

    // A taken branch spends one extra cycle refilling the fetch
    always_comb begin
        next_state = state;
        unique case (state)
            CBU_ST_IDLE: begin
                if (accept && cond) begin
                    next_state = CBU_ST_SECOND;
                end
            end
            CBU_ST_SECOND: next_state = CBU_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= CBU_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Counter load strobe, one cycle after a taken acceptance
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_load_o <= CBU_LOAD_RST;
        end else begin
            pc_load_o <= accept & cond;
        end
    end

    // Target register; it keeps the last taken target, since only the
    // strobe tells the counter to load it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pc_target_o <= CBU_PC_RST;
        end else if (accept && cond) begin
            pc_target_o <= next_target;
        end
    end

    // Completion: end of cycle one when falling through, two if taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= CBU_DONE_RST;
        end else begin
            done_o <= (accept & ~cond) | (state == CBU_ST_SECOND);
        end
    end

    // Outcome of the last accepted branch, held until the next one
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            taken_o <= CBU_LOAD_RST;
        end else if (accept) begin
            taken_o <= cond;
        end
    end

    // Branches never touch the status flags
    assign flag_wr_o = 1'b0;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Checks sleep while reset is high; the helper copies restart from
    // constants so no stale decision is judged after a mid-run reset

    // Helper: copies of what the accepting edge saw, so a decision
    // shown one cycle later is judged against the request, flags and
    // counter that produced it
    logic acc_q;
    cbu_op_t op_q;
    cbu_flags_t fl_q;
    logic [CBU_PC_W-1:0] pc_q;
    logic [CBU_OFS_W-1:0] ofs_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_q <= 1'b0;
            op_q <= CBU_BR_POSITIVE;
            fl_q <= '0;
            pc_q <= CBU_PC_RST;
            ofs_q <= '0;
        end else begin
            acc_q <= accept;
            op_q <= req_i.op;
            fl_q <= cur_flags;
            pc_q <= pc_i;
            ofs_q <= req_i.offset;
        end
    end

    positive_test_a: assert property (
        acc_q && op_q == CBU_BR_POSITIVE |-> pc_load_o == !fl_q.neg)
        else $error("positive branch decision wrong");
    sge_test_a: assert property (
        acc_q && op_q == CBU_BR_SGE |-> pc_load_o == !(fl_q.neg ^ fl_q.ovf))
        else $error("signed ge branch decision wrong");
    slt_test_a: assert property (
        acc_q && op_q == CBU_BR_SLT |-> pc_load_o == (fl_q.neg ^ fl_q.ovf))
        else $error("signed lt branch decision wrong");
    hc_set_a: assert property (
        acc_q && op_q == CBU_BR_HC_SET |-> pc_load_o == fl_q.half)
        else $error("half carry set decision wrong");
    hc_clear_a: assert property (
        acc_q && op_q == CBU_BR_HC_CLR |-> pc_load_o == !fl_q.half)
        else $error("half carry clear decision wrong");
    tb_set_a: assert property (
        acc_q && op_q == CBU_BR_TB_SET |-> pc_load_o == fl_q.xfer)
        else $error("transfer bit set decision wrong");
    tb_clear_a: assert property (
        acc_q && op_q == CBU_BR_TB_CLR |-> pc_load_o == !fl_q.xfer)
        else $error("transfer bit clear decision wrong");
    ov_set_a: assert property (
        acc_q && op_q == CBU_BR_OV_SET |-> pc_load_o == fl_q.ovf)
        else $error("overflow set decision wrong");

    // Target checked with an independent signed sum
    branch_target_a: assert property (
        acc_q && pc_load_o |-> pc_target_o ==
            CBU_PC_W'($signed(pc_q) + $signed(ofs_q) + 1))
        else $error("branch target not pc plus offset plus one");
    offset_sign_a: assert property (
        acc_q && pc_load_o && ofs_q[CBU_OFS_W-1] |->
            pc_target_o != pc_q + {5'h00, ofs_q} + CBU_PC_ONE ||
            ofs_q == 7'h40)
        else $error("offset not sign extended");

    // Cycle counts and flag silence
    fall_one_cycle_a: assert property (
        accept && !cond |=> done_o && ready_o)
        else $error("fall-through not done in one cycle");
    taken_two_cycle_a: assert property (
        accept && cond |=> !done_o && !ready_o ##1 done_o && ready_o)
        else $error("taken branch not done in two cycles");
    flags_untouched_a: assert property (
        !flag_wr_o)
        else $error("branch unit wrote a flag");

    // A same-cycle flag write decides the branch
    forward_flags_a: assert property (
        accept && flag_wr_i && req_i.op == CBU_BR_OV_SET |=>
            pc_load_o == $past(flag_wdata_i.ovf))
        else $error("fresh flag write not honoured");
    fwd_half_a: assert property (
        accept && flag_wr_i && req_i.op == CBU_BR_HC_SET |=>
            pc_load_o == $past(flag_wdata_i.half))
        else $error("fresh half carry not honoured");
    fwd_sign_a: assert property (
        accept && flag_wr_i && req_i.op == CBU_BR_POSITIVE |=>
            pc_load_o == !$past(flag_wdata_i.neg))
        else $error("fresh negative flag not honoured");

    // Without a write the flag register itself decides; a positive offset adds without extension
    stale_flags_a: assert property (
        accept && !flag_wr_i && req_i.op == CBU_BR_OV_SET |=>
            pc_load_o == $past(flags_i.ovf))
        else $error("flag register not used without a write");
    offset_pos_a: assert property (
        acc_q && pc_load_o && !ofs_q[CBU_OFS_W-1] |->
            pc_target_o == pc_q + {5'h00, ofs_q} + CBU_PC_ONE)
        else $error("positive offset target wrong");

    // Outputs that stand: target and outcome move only on a branch
    target_hold_a: assert property (
        !pc_load_o |-> $stable(pc_target_o))
        else $error("target moved without a load");
    taken_hold_a: assert property (
        !acc_q |-> $stable(taken_o))
        else $error("outcome moved without a branch");
    load_is_taken_a: assert property (
        acc_q |-> taken_o == pc_load_o)
        else $error("outcome and load strobe disagree");

    // Handshake: one refused cycle after a taken branch, never more
    ready_tracks_a: assert property (
        ready_o == !pc_load_o)
        else $error("ready not low exactly after a taken branch");
    refused_quiet_a: assert property (
        !ready_o |=> !pc_load_o)
        else $error("refused request started a branch");
    load_pulse_a: assert property (
        pc_load_o |=> !pc_load_o && done_o)
        else $error("load strobe not one cycle or no completion");
    done_idle_a: assert property (
        done_o |-> ready_o && !pc_load_o)
        else $error("completion while still busy");
    fall_no_load_a: assert property (
        acc_q && !taken_o |-> !pc_load_o && done_o)
        else $error("fall-through loaded the counter");

    taken_seen_c: cover property (accept && cond ##1 pc_load_o ##1 done_o);
    fall_seen_c: cover property (accept && !cond ##1 done_o);
    back_back_c: cover property (accept && !cond ##1 accept);
    forward_seen_c: cover property (accept && flag_wr_i && cond);
    refused_seen_c: cover property (req_valid_i && !ready_o);

endmodule

// file: rtl/cbu_pkg.sv
/*
 * Shared types and constants of the conditional branch unit: branch
 * selector codes, the status flag layout, the decode request and the
 * reset values of the unit's registers.
 * Assumes an 8-bit core with a 12-bit word-addressed program counter.
 */
package cbu_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CBU_PC_W = 12;
    localparam int CBU_OFS_W = 7;
    localparam int CBU_EXT_W = CBU_PC_W - CBU_OFS_W;

    // ************************************************************
    // Values after reset and fixed increments
    // ************************************************************
    localparam logic [CBU_PC_W-1:0] CBU_PC_RST = 12'h000;
    localparam logic [CBU_PC_W-1:0] CBU_PC_ONE = 12'h001;
    localparam logic CBU_LOAD_RST = 1'b0;
    localparam logic CBU_DONE_RST = 1'b0;

    // ************************************************************
    // Cycle counts of one branch
    // ************************************************************
    localparam int CBU_CYC_FALL = 1;
    localparam int CBU_CYC_TAKEN = 2;

    // Branch selector driven by instruction decode
    typedef enum logic [2:0] {
        CBU_BR_POSITIVE = 3'h0,
        CBU_BR_SGE = 3'h1,
        CBU_BR_SLT = 3'h2,
        CBU_BR_HC_SET = 3'h3,
        CBU_BR_HC_CLR = 3'h4,
        CBU_BR_TB_SET = 3'h5,
        CBU_BR_TB_CLR = 3'h6,
        CBU_BR_OV_SET = 3'h7
    } cbu_op_t;

    // Status flags, most significant first
    typedef struct packed {
        logic irq_en;
        logic xfer;
        logic half;
        logic sign;
        logic ovf;
        logic neg;
        logic zero;
        logic carry;
    } cbu_flags_t;

    // One decoded branch instruction
    typedef struct packed {
        cbu_op_t op;
        logic [CBU_OFS_W-1:0] offset;
    } cbu_req_t;

    // Sequencer states, Gray along idle -> second cycle -> idle
    typedef enum logic {
        CBU_ST_IDLE = 1'b0,
        CBU_ST_SECOND = 1'b1
    } cbu_state_t;

endpackage

// file: sim/conditional_branch_unit_test.sv
/*
 * Self-checking bench of the conditional branch unit: reset values, all
 * eight selectors over every mix of the tested flags, offset sign and
 * wrap, refusal after a taken branch and same-cycle flag forwarding.
 * Assumes the cbu_pkg types and one 100 MHz clock; the bench drives
 * every port itself.
 */
`timescale 1ns/1ps
module conditional_branch_unit_test;
    import cbu_pkg::*;

    logic clk_i;
    logic sys_rst_i;
    logic req_valid_i;
    cbu_req_t req_i;
    logic [CBU_PC_W-1:0] pc_i;
    cbu_flags_t flags_i;
    logic flag_wr_i;
    cbu_flags_t flag_wdata_i;
    logic ready_o;
    logic pc_load_o;
    logic [CBU_PC_W-1:0] pc_target_o;
    logic done_o;
    logic taken_o;
    logic flag_wr_o;
    int n_errors = 0;
    int compares = 0;

    cbu_branch cbu_branch_inst (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i),
        .req_i(req_i),
        .pc_i(pc_i),
        .flags_i(flags_i),
        .flag_wr_i(flag_wr_i),
        .flag_wdata_i(flag_wdata_i),
        .ready_o(ready_o),
        .pc_load_o(pc_load_o),
        .pc_target_o(pc_target_o),
        .done_o(done_o),
        .taken_o(taken_o),
        .flag_wr_o(flag_wr_o)
    );

    // ************************************************************
    // Clock, watchdog and shared helpers
    // ************************************************************
    // Core clock, 10 ns period
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // About 220 cycles expected; cut a hang well past that
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end

    // Case equality so an unknown never passes
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected outcome, written from the flag tests themselves
    function automatic logic cond_of(cbu_op_t op, cbu_flags_t f);
        case (op)
            CBU_BR_POSITIVE: return !f.neg;
            CBU_BR_SGE: return !(f.neg ^ f.ovf);
            CBU_BR_SLT: return f.neg ^ f.ovf;
            CBU_BR_HC_SET: return f.half;
            CBU_BR_HC_CLR: return !f.half;
            CBU_BR_TB_SET: return f.xfer;
            CBU_BR_TB_CLR: return !f.xfer;
            default: return f.ovf;
        endcase
    endfunction

    // One branch; valid stays up afterwards, so a taken branch also
    // proves the held request is refused during its second cycle
    task automatic do_branch(input cbu_op_t op, input logic [6:0] ofs,
            input logic [11:0] pc, input cbu_flags_t f, input logic fwr,
            input cbu_flags_t fw);
        logic tk;
        logic [11:0] tgt;
        tk = cond_of(op, fwr ? fw : f);
        tgt = pc + {{CBU_EXT_W{ofs[6]}}, ofs} + CBU_PC_ONE;
        req_valid_i = 1'b1;
        req_i = {op, ofs};
        pc_i = pc;
        flags_i = f;
        flag_wr_i = fwr;
        flag_wdata_i = fw;
        check(ready_o, 1'b1);
        @(posedge clk_i);
        #1;
        check(taken_o, tk);
        check(pc_load_o, tk);
        check(done_o, !tk);
        check(flag_wr_o, 1'b0);
        if (tk) begin
            // Write pulse ends; a fall-through leaves it to the next call
            flag_wr_i = 1'b0;
            check(pc_target_o, tgt);
            check(ready_o, 1'b0);
            @(posedge clk_i);
            #1;
            check(done_o, 1'b1);
            check(pc_load_o, 1'b0);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Every selector against all 16 mixes of N, V, H and T; the
    // unused write data is inverted so a wrong flag source shows
    task automatic run_table();
        cbu_flags_t f;
        for (int i = 0; i < 128; i++) begin
            f = cbu_flags_t'(8'h00);
            f.neg = i[3];
            f.ovf = i[4];
            f.half = i[5];
            f.xfer = i[6];
            f.zero = i[0];
            do_branch(cbu_op_t'(i[2:0]), 7'(i * 13), 12'(i * 37), f,
                1'b0, ~f);
        end
    endtask

    // Offset extremes and counter wrap, always taken
    task automatic wrap_offsets();
        cbu_flags_t t;
        t = cbu_flags_t'(8'h40);
        do_branch(CBU_BR_TB_SET, 7'h00, 12'hFFF, t, 1'b0, t);
        do_branch(CBU_BR_TB_SET, 7'h40, 12'h005, t, 1'b0, t);
        do_branch(CBU_BR_TB_SET, 7'h3F, 12'h100, t, 1'b0, t);
        do_branch(CBU_BR_TB_SET, 7'h7F, 12'h000, t, 1'b0, t);
    endtask

    // Flags written in the accept cycle must win over the old ones
    task automatic forward_flags();
        cbu_flags_t f;
        f = cbu_flags_t'(8'h04);
        do_branch(CBU_BR_POSITIVE, 7'h05, 12'h200, f, 1'b1, ~f);
        do_branch(CBU_BR_HC_SET, 7'h7B, 12'h300, f, 1'b1, ~f);
        do_branch(CBU_BR_HC_CLR, 7'h02, 12'h400, ~f, 1'b1, f);
        do_branch(CBU_BR_OV_SET, 7'h10, 12'h500, f, 1'b1, ~f);
        do_branch(CBU_BR_OV_SET, 7'h10, 12'h600, ~f, 1'b1, f);
        do_branch(CBU_BR_POSITIVE, 7'h05, 12'h700, ~f, 1'b1, f);
    endtask

    // Reset values, once at the start and once in mid-run, where taken
    // branches have just left a target and an outcome to be cleared
    task automatic reset_values();
        sys_rst_i = 1'b1;
        req_valid_i = 1'b0;
        flag_wr_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        check(ready_o, 1'b1);
        check(pc_load_o, CBU_LOAD_RST);
        check(pc_target_o, CBU_PC_RST);
        check(done_o, CBU_DONE_RST);
        check(taken_o, 1'b0);
        check(flag_wr_o, 1'b0);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        req_i = '0;
        pc_i = '0;
        flags_i = '0;
        flag_wdata_i = '0;
        reset_values();
        run_table();
        reset_values();
        wrap_offsets();
        forward_flags();
        req_valid_i = 1'b0;
        flag_wr_i = 1'b0;
        @(posedge clk_i);
        #1;
        check(done_o, 1'b0);
        check(pc_load_o, 1'b0);
        finish_test();
    end
endmodule
